// file: measurement_handler_handshake_tb.sv
// Purpose: drives both ends across the link and judges captured results
// Assumes: shortened counts; kinds 0 meas, 1 check, 2 cap corr, 3 res corr
// Notes: the 36-cycle wait covers request qualify plus the release delay
`timescale 1ns/1ps
module measurement_handler_handshake_tb;
   import mhh_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic conv_complete = 1'b0;
   logic malfunction = 1'b0;
   logic start = 1'b0;
   logic display_on = 1'b1;
   logic [1:0] start_kind = 2'h0;
   logic [7:0] res_b = 8'h00, res_w = 8'h00, res_a = 8'h00, res_nc = 8'h00;
   logic busy, ready, result_valid;
   logic [1:0] active_req;
   logic [7:0] got_b, got_w, got_a, got_nc;
   int err_total = 0;
   int tests_run = 0;
   realtime t_eom = 0.0, t_meas_req = 0.0;
   // shortened counts for both ends; the checker's fixed bounds assume these values
   localparam int D_PULSE = 20, D_ACK = 10, D_EOM = 30, D_CC_CONV = 40, D_CC_EOM = 30;
   localparam int D_CX_CONV = 50, D_CX_EOM = 20, D_IR_CONV = 60, D_IR_EOM = 20;
   localparam int H_PULSE = 24, H_HIGH = 20, H_DISP = 100, H_NODISP = 30, H_LONG = 150;
   mhh_link_if link ();
   mhh_device #(.PULSE_CYC(D_PULSE), .ACK_CYC(D_ACK), .EOM_GAP_CYC(D_EOM), .CC_CONV_CYC(D_CC_CONV),
      .CC_EOM_CYC(D_CC_EOM), .CX_CONV_CYC(D_CX_CONV), .CX_EOM_CYC(D_CX_EOM), .IR_CONV_CYC(D_IR_CONV),
      .IR_EOM_CYC(D_IR_EOM)) mhh_device_inst (
      .sys_clk(sys_clk), .resetn(resetn), .link(link), .conv_complete(conv_complete), .res_below(res_b),
      .res_within(res_w), .res_above(res_a), .res_no_contact(res_nc), .malfunction(malfunction),
      .busy(busy), .active_req(active_req));
   mhh_host #(.PULSE_CYC(H_PULSE), .HIGH_CYC(H_HIGH), .SETUP_DISP_CYC(H_DISP), .SETUP_NODISP_CYC(H_NODISP),
      .SETUP_LONG_CYC(H_LONG)) mhh_host_inst (
      .sys_clk(sys_clk), .resetn(resetn), .link(link), .start(start), .start_kind(start_kind),
      .display_on(display_on), .ready(ready), .result_valid(result_valid), .got_below(got_b),
      .got_within(got_w), .got_above(got_a), .got_no_contact(got_nc));
   mhh_link_asserts mhh_link_asserts_inst (
      .sys_clk(sys_clk), .resetn(resetn), .measure_trigger_in_n(link.measure_trigger_in_n),
      .contact_check_req_n(link.contact_check_req_n), .capacitance_open_corr_req_n(link.capacitance_open_corr_req_n),
      .resistance_open_corr_req_n(link.resistance_open_corr_req_n), .conv_done_n(link.conv_done_n),
      .end_of_meas_n(link.end_of_meas_n), .below_limit_out_n(link.below_limit_out_n),
      .within_limit_out_n(link.within_limit_out_n), .above_limit_out_n(link.above_limit_out_n),
      .no_contact_out_n(link.no_contact_out_n));
   // clock and edge time stamps for the setup-gap check
   always #2 sys_clk = ~sys_clk;
   always @(negedge link.end_of_meas_n) t_eom = $realtime;
   always @(negedge link.measure_trigger_in_n) t_meas_req = $realtime;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
         err_total++;
      if (got !== exp)
         $display("unexpected at %0t: exp %h got %h", $time, exp, got);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait on ready (sel 0) or the result pulse (sel 1)
   task automatic wait_for(input int sel, input int lim);
      int n;
      n = 0;
      while ((sel == 0 ? ready : result_valid) !== 1'b1) begin
         cyc(1);
         n++;
         if (n > lim) begin
            err_total++;
            $display("unexpected at %0t: wait %h ran past %h cycles", $time, sel, lim);
            report_and_stop();
         end
      end
   endtask
   // one whole operation; conversion end is fed only for a normal measurement
   task automatic run_op(input logic [1:0] kind, input logic disp);
      wait_for(0, 400);
      display_on = disp;
      start_kind = kind;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      cyc(36);
      chk(8'h01, {7'h00, busy});
      chk({6'h00, kind}, {6'h00, active_req});
      if (kind == 2'h0) begin
         conv_complete = 1'b1;
         cyc(1);
         conv_complete = 1'b0;
      end
      wait_for(1, 400);
   endtask
   task automatic sc_meas(input logic disp, input int setup, input logic [7:0] b, w, a, nc);
      realtime prev;
      res_b = b;
      res_w = w;
      res_a = a;
      res_nc = nc;
      prev = t_eom;
      run_op(2'h0, disp);
      if (setup > 0)
         chk(8'h01, {7'h00, (t_meas_req - prev) >= setup * 4.0});
      chk(b, got_b);
      chk(w, got_w);
      chk(a, got_a);
      chk(nc, got_nc);
      chk(~b, link.below_limit_out_n);
      chk(~a, link.above_limit_out_n);
      $display("test meas done");
   endtask
   task automatic sc_other(input logic [1:0] kind);
      logic [7:0] keep_b;
      keep_b = res_b;
      res_b = ~res_b;
      res_nc = 8'hA5;
      run_op(kind, 1'b0);
      if (kind == 2'h1)
         chk(8'hA5, got_nc);
      if (kind == 2'h1)
         chk(8'h5A, link.no_contact_out_n);
      if (kind != 2'h1)
         chk(keep_b, got_b);
      chk(8'h00, {6'h00, link.conv_done_n, link.end_of_meas_n});
      // the long hold-off must run to its end, not stop at a measurement's short one
      cyc(H_LONG - 2);
      chk(8'h00, {7'h00, ready});
      cyc(4);
      chk(8'h01, {7'h00, ready});
      res_b = keep_b;
      $display("test kind %h done", kind);
   endtask
   task automatic sc_alarm();
      malfunction = 1'b1;
      cyc(3);
      chk(8'h00, {7'h00, link.alarm_n});
      malfunction = 1'b0;
      cyc(3);
      chk(8'h01, {7'h00, link.alarm_n});
      $display("test alarm done");
   endtask
   // reset lands while a request is served; both done lines, the within-limit flags, ready and busy must fall back to idle
   task automatic sc_reset();
      wait_for(0, 400);
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      cyc(30);
      resetn = 1'b0;
      cyc(2);
      chk(8'h06, {5'h00, link.conv_done_n, link.end_of_meas_n, ready});
      chk(8'hFF, link.within_limit_out_n);
      chk(8'h00, {7'h00, busy});
      resetn = 1'b1;
      $display("test reset done");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      sc_meas(1'b1, 0, 8'h03, 8'h3C, 8'hC0, 8'h00);
      sc_meas(1'b1, H_DISP, 8'hC0, 8'h0F, 8'h30, 8'h81);
      sc_meas(1'b0, 0, 8'h11, 8'h66, 8'h88, 8'h00);
      sc_meas(1'b0, H_NODISP, 8'h80, 8'h7E, 8'h01, 8'h42);
      sc_other(2'h1);
      sc_other(2'h2);
      sc_other(2'h3);
      sc_alarm();
      sc_reset();
      sc_meas(1'b0, 0, 8'h0F, 8'hF0, 8'h00, 8'h18);
      report_and_stop();
   end
endmodule

// file: mhh_device.sv
// Purpose: instrument end of the handler handshake
// Assumes: request inputs synchronous to sys_clk; measurement core gives results
// Notes: fixed internal delays sit well inside the time limits, except the correction delays, which are set to the full figures
// Behaviour
// R1: trigger held low at least 100 us
// R2: trigger high at least 100 us between
// R3: release done outputs within 200/400 us
// R4: conversion-done falls when conversion completes
// R5: conversion-done within measure time plus delay
// R6: end-of-measurement within 500 us after
// R7: results valid at end-of-measurement fall
// R8: controller waits 30 ms or 1 ms
// R9: no-contact outputs within 3 ms
// R10: other requests held low 100 us
// R11: capacitance request starts capacitance correction
// R12: resistance request starts resistance correction
// R13: correction durations 8/10 ms, 5 s
// R14: controller waits 2 s after correction
// R15: contact-check request checks all channels
// R16: contact-check phases within 4 ms each
// R17: no-contact settled 100 us before completion
// R18: controller waits 2 s after check
// R19: per-channel below/within/above outputs
// R20: per-channel no-contact output
// R21: all outputs active low
// R22: one action per qualified falling edge
`timescale 1ns/1ps
`include "mhh_map.svh"
module mhh_device
   import mhh_pkg::*;
#(
   parameter int CHANNELS = `MHH_CHANNELS,
   parameter int PULSE_CYC = `MHH_US_CYC(`MHH_MIN_PULSE_US),
   parameter int ACK_CYC = `MHH_US_CYC(`MHH_ACK_NORM_US) / 2,
   parameter int EOM_GAP_CYC = `MHH_US_CYC(`MHH_EOM_AFTER_US) / 2,
   parameter int CC_CONV_CYC = `MHH_MS_CYC(`MHH_CC_PHASE_MS) / 2,
   parameter int CC_EOM_CYC = `MHH_US_CYC(`MHH_JUDGE_SETUP_US) * 2,
   parameter int CX_CONV_CYC = `MHH_MS_CYC(`MHH_CX_INDEX_MS),
   parameter int CX_EOM_CYC = `MHH_MS_CYC(`MHH_CX_EOM_MS) - `MHH_MS_CYC(`MHH_CX_INDEX_MS),
   parameter int IR_CONV_CYC = `MHH_S_CYC(`MHH_IR_EACH_S),
   parameter int IR_EOM_CYC = `MHH_S_CYC(`MHH_IR_EACH_S)
) (
   input wire logic sys_clk, // 250 MHz clock
   input wire logic resetn, // async reset, active low
   mhh_link_if.dev link, // handler lines
   input wire logic conv_complete, // pulse: measurement core finished conversion
   input wire logic [CHANNELS-1:0] res_below, // per-channel below-limit result
   input wire logic [CHANNELS-1:0] res_within, // per-channel within-limit result
   input wire logic [CHANNELS-1:0] res_above, // per-channel above-limit result
   input wire logic [CHANNELS-1:0] res_no_contact, // per-channel open contact
   input wire logic malfunction, // instrument fault level
   output logic busy, // an operation is in progress
   output logic [1:0] active_req // kind of current operation
);
   localparam int CW = 31;
   // request inputs, qualified by low width
   logic [3:0] req_n;
   logic [3:0] armed;
   logic [CW-1:0] low_cnt [4];
   logic [3:0] qualified;
   assign req_n = {link.resistance_open_corr_req_n, link.capacitance_open_corr_req_n,
                   link.contact_check_req_n, link.measure_trigger_in_n};

   // each line counts its own low time; a request fires once when the width is met [R22]
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_req
         assign qualified[g] = armed[g] && !req_n[g] && (low_cnt[g] == CW'(PULSE_CYC - 1)); // [R1] [R10]
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               low_cnt[g] <= '0;
               armed[g] <= 1'b0;
            end else begin
               if (req_n[g]) low_cnt[g] <= '0;
               else if (low_cnt[g] != CW'(PULSE_CYC - 1)) low_cnt[g] <= low_cnt[g] + 1'b1;
               if (req_n[g]) armed[g] <= 1'b1; // re-armed only after the line rose [R22]
               else if (qualified[g]) armed[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // priority: contact check, capacitance, resistance, then trigger
   logic any_req;
   mhh_req_t new_kind;
   assign any_req = |qualified;
   assign new_kind = qualified[1] ? MHH_REQ_CHECK : qualified[2] ? MHH_REQ_CX :
                     qualified[3] ? MHH_REQ_IR : MHH_REQ_MEAS;

   mhh_dev_state_t state;
   mhh_req_t kind;
   logic [CW-1:0] tmr;
   logic conv_n, eom_n, alarm_q;
   logic [CHANNELS-1:0] below_q, in_q, above_q, nc_q;
   logic tmr_done;
   logic conv_event;
   logic [CW-1:0] conv_len, eom_len;
   assign tmr_done = (tmr == '0);
   assign conv_len = (kind == MHH_REQ_CHECK) ? CW'(CC_CONV_CYC) :
                     (kind == MHH_REQ_CX) ? CW'(CX_CONV_CYC) : CW'(IR_CONV_CYC); // [R13] [R16]
   assign eom_len = (kind == MHH_REQ_MEAS) ? CW'(EOM_GAP_CYC) :
                    (kind == MHH_REQ_CHECK) ? CW'(CC_EOM_CYC) :
                    (kind == MHH_REQ_CX) ? CW'(CX_EOM_CYC) : CW'(IR_EOM_CYC);
   // normal measurements end conversion on the core's pulse; others are timed
   assign conv_event = (kind == MHH_REQ_MEAS) ? conv_complete : tmr_done; // [R4] [R5]

   // sequence: ack delay, release outputs, conversion, end-of-measurement
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= MHH_D_IDLE;
         kind <= MHH_REQ_MEAS;
         tmr <= '0;
         conv_n <= 1'b1;
         eom_n <= 1'b1;
      end else begin
         if (!tmr_done) tmr <= tmr - 1'b1;
         unique case (state)
            MHH_D_IDLE: begin
               if (any_req) begin
                  kind <= new_kind; // [R11] [R12] [R15]
                  tmr <= CW'(ACK_CYC);
                  state <= MHH_D_ACK;
               end
            end
            MHH_D_ACK: begin
               if (tmr_done) begin
                  conv_n <= 1'b1; // release both well inside the limit [R3]
                  eom_n <= 1'b1;
                  tmr <= conv_len;
                  state <= MHH_D_CONV;
               end
            end
            MHH_D_CONV: begin
               if (conv_event) begin
                  conv_n <= 1'b0; // [R4]
                  tmr <= eom_len;
                  state <= MHH_D_EOM;
               end
            end
            MHH_D_EOM: begin
               if (tmr_done) begin
                  eom_n <= 1'b0; // [R6]
                  state <= MHH_D_IDLE;
               end
            end
            // never entered; a stray code falls back to idle rather than hanging
            MHH_D_HOLD: state <= MHH_D_IDLE;
         endcase
      end
   end

   // results latch before end-of-measurement falls, so they are stable at that edge [R7]
   logic load_judge;
   logic load_nc;
   assign load_judge = (state == MHH_D_CONV) && conv_event && (kind == MHH_REQ_MEAS);
   // no-contact loads at conversion end: for a check this is CC_EOM_CYC before completion [R17] [R9]
   assign load_nc = (state == MHH_D_CONV) && conv_event &&
                    ((kind == MHH_REQ_MEAS) || (kind == MHH_REQ_CHECK));
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         below_q <= '0;
         in_q <= '0;
         above_q <= '0;
         nc_q <= '0;
         alarm_q <= 1'b0;
      end else begin
         alarm_q <= malfunction;
         if (load_judge) begin
            below_q <= res_below; // [R19]
            in_q <= res_within;
            above_q <= res_above;
         end
         if (load_nc) nc_q <= res_no_contact; // [R20]
      end
   end

   // link outputs are inverted registers, low means asserted [R21]; busy and active_req are active high
   logic [CHANNELS-1:0] below_n, in_n, above_n, nc_n;
   logic alarm_out_n;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         below_n <= '1;
         in_n <= '1;
         above_n <= '1;
         nc_n <= '1;
         alarm_out_n <= 1'b1;
         busy <= 1'b0;
         active_req <= 2'h0;
      end else begin
         below_n <= ~below_q; // [R21]
         in_n <= ~in_q;
         above_n <= ~above_q;
         nc_n <= ~nc_q;
         alarm_out_n <= ~alarm_q; // one more cycle of alarm latency keeps the pin glitch free
         busy <= (state != MHH_D_IDLE);
         active_req <= kind;
      end
   end

   // link pins come straight from the registers above, no gate in between
   assign link.conv_done_n = conv_n;
   assign link.end_of_meas_n = eom_n;
   assign link.alarm_n = alarm_out_n; // [R21]
   assign link.below_limit_out_n = below_n;
   assign link.within_limit_out_n = in_n;
   assign link.above_limit_out_n = above_n;
   assign link.no_contact_out_n = nc_n;
endmodule

// file: mhh_host.sv
// Purpose: controller end: issues requests and captures results
// Assumes: user start is a one-cycle pulse; one operation at a time
// Notes: enforces pulse width, high time and setup waits
`timescale 1ns/1ps
`include "mhh_map.svh"
module mhh_host
   import mhh_pkg::*;
#(
   parameter int CHANNELS = `MHH_CHANNELS,
   parameter int PULSE_CYC = `MHH_US_CYC(`MHH_MIN_PULSE_US) + 4,
   parameter int HIGH_CYC = `MHH_US_CYC(`MHH_MIN_HIGH_US),
   parameter int SETUP_DISP_CYC = `MHH_MS_CYC(`MHH_SETUP_DISP_MS),
   parameter int SETUP_NODISP_CYC = `MHH_MS_CYC(`MHH_SETUP_NODISP_MS),
   parameter int SETUP_LONG_CYC = `MHH_S_CYC(`MHH_POST_SETUP_S)
) (
   input wire logic sys_clk, // 250 MHz clock
   input wire logic resetn, // async reset, active low
   mhh_link_if.host link, // handler lines
   input wire logic start, // pulse: begin an operation
   input wire logic [1:0] start_kind, // operation kind
   input wire logic display_on, // instrument display enabled
   output logic ready, // may accept start
   output logic result_valid, // pulse: results captured
   output logic [CHANNELS-1:0] got_below, // captured below-limit
   output logic [CHANNELS-1:0] got_within, // captured within-limit
   output logic [CHANNELS-1:0] got_above, // captured above-limit
   output logic [CHANNELS-1:0] got_no_contact // captured no-contact
);
   localparam int CW = 31;
   mhh_host_state_t state;
   mhh_req_t kind;
   logic [CW-1:0] tmr;
   logic [3:0] drive_n;
   logic eom_prev;
   logic eom_fall;
   logic tmr_done;
   logic [CW-1:0] setup_len;
   assign tmr_done = (tmr == '0);
   assign eom_fall = eom_prev && !link.end_of_meas_n;
   // setup wait depends on the kind of operation just ended
   assign setup_len = (kind != MHH_REQ_MEAS) ? CW'(SETUP_LONG_CYC) : // [R14] [R18]
                      display_on ? CW'(SETUP_DISP_CYC) : CW'(SETUP_NODISP_CYC); // [R8]
   assign link.measure_trigger_in_n = drive_n[0];
   assign link.contact_check_req_n = drive_n[1];
   assign link.capacitance_open_corr_req_n = drive_n[2];
   assign link.resistance_open_corr_req_n = drive_n[3];

   // sequencer: pulse low, wait for end-of-measurement, then hold off
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= MHH_H_IDLE;
         kind <= MHH_REQ_MEAS;
         tmr <= '0;
         drive_n <= 4'hF;
         eom_prev <= 1'b1;
         ready <= 1'b0;
         result_valid <= 1'b0;
         got_below <= '0;
         got_within <= '0;
         got_above <= '0;
         got_no_contact <= '0;
      end else begin
         eom_prev <= link.end_of_meas_n;
         result_valid <= 1'b0;
         if (!tmr_done) tmr <= tmr - 1'b1;
         unique case (state)
            MHH_H_IDLE: begin
               ready <= tmr_done && !start; // guard on the timer, last loaded with the setup hold-off, not the pulse's high time [R2]
               if (start && ready) begin
                  kind <= mhh_req_t'(start_kind);
                  drive_n <= ~(4'h1 << start_kind); // [R22]
                  tmr <= CW'(PULSE_CYC);
                  ready <= 1'b0;
                  state <= MHH_H_PULSE;
               end
            end
            MHH_H_PULSE: begin
               if (tmr_done) begin
                  drive_n <= 4'hF; // width met [R1] [R10]
                  tmr <= CW'(HIGH_CYC);
                  state <= MHH_H_WAIT_EOM;
               end
            end
            MHH_H_WAIT_EOM: begin
               if (eom_fall) begin
                  got_below <= ~link.below_limit_out_n; // capture at the falling edge [R7]
                  got_within <= ~link.within_limit_out_n;
                  got_above <= ~link.above_limit_out_n;
                  got_no_contact <= ~link.no_contact_out_n;
                  result_valid <= 1'b1;
                  tmr <= setup_len;
                  state <= MHH_H_SETUP;
               end
            end
            MHH_H_SETUP: begin
               if (tmr_done) begin
                  state <= MHH_H_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// file: mhh_link_asserts.sv
// Purpose: concurrent checks on the handler lines between the two ends
// Assumes: the shortened cycle counts set by the bench
// Notes: bounds are scaled figures, not the real microsecond limits
`timescale 1ns/1ps
module mhh_link_asserts (
   input wire logic sys_clk, // clock
   input wire logic resetn, // async reset, active low
   input wire logic measure_trigger_in_n, // trigger request
   input wire logic contact_check_req_n, // contact-check request
   input wire logic capacitance_open_corr_req_n, // capacitance correction request
   input wire logic resistance_open_corr_req_n, // resistance correction request
   input wire logic conv_done_n, // conversion done
   input wire logic end_of_meas_n, // end of measurement
   input wire logic [7:0] below_limit_out_n, // below-limit flags
   input wire logic [7:0] within_limit_out_n, // within-limit flags
   input wire logic [7:0] above_limit_out_n, // above-limit flags
   input wire logic [7:0] no_contact_out_n // no-contact flags
);
   localparam int ACK_MAX = 40;
   localparam int EOM_MAX = 40;
   localparam int CC_MAX = 120;
   wire logic req_all_n = measure_trigger_in_n & contact_check_req_n & capacitance_open_corr_req_n
      & resistance_open_corr_req_n;
   logic [7:0] low_len;
   logic [7:0] high_len;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // run lengths of the merged request line; high starts saturated so a first request is legal
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         low_len <= 8'h00;
         high_len <= 8'hFF;
      end else begin
         low_len <= req_all_n ? 8'h00 : low_len + 8'h01;
         high_len <= !req_all_n ? 8'h00 : (high_len == 8'hFF ? high_len : high_len + 8'h01);
      end
   end
   a_req_low_width: assert property ($rose(req_all_n) |-> low_len >= 8'h14)
      else $error("request pulse too short");
   a_req_high_gap: assert property ($fell(req_all_n) |-> high_len >= 8'h14)
      else $error("request high time too short");
   a_ack_release: assert property ($fell(req_all_n) |-> ##[1:ACK_MAX] (conv_done_n && end_of_meas_n))
      else $error("done lines not released in time");
   a_eom_after_conv: assert property ($fell(conv_done_n) |-> ##[1:EOM_MAX] !end_of_meas_n)
      else $error("end of measurement late");
   a_conv_before_eom: assert property ($fell(end_of_meas_n) |-> !conv_done_n)
      else $error("end of measurement before conversion done");
   a_conv_done_holds: assert property ($fell(conv_done_n) |=> (!conv_done_n) [*8])
      else $error("conversion done did not stand");
   a_results_stand: assert property (!end_of_meas_n && !$past(end_of_meas_n) |->
      $stable({below_limit_out_n, within_limit_out_n, above_limit_out_n, no_contact_out_n}))
      else $error("results moved while end of measurement low");
   a_check_bound: assert property ($fell(contact_check_req_n) |-> ##[1:CC_MAX] $fell(end_of_meas_n))
      else $error("contact check too slow");
   a_judge_settled: assert property ($fell(end_of_meas_n) |-> no_contact_out_n == $past(no_contact_out_n, 8))
      else $error("no-contact not settled before completion");
   c_meas: cover property ($fell(measure_trigger_in_n) ##[1:200] $fell(end_of_meas_n));
   c_check: cover property ($fell(contact_check_req_n) ##[1:CC_MAX] $fell(end_of_meas_n));
   c_corr: cover property ($fell(capacitance_open_corr_req_n) ##[1:200] $fell(end_of_meas_n));
endmodule

// file: mhh_link_if.sv
// Purpose: the isolated handler I/O lines between instrument and controller
// Assumes: all lines active low, one clock domain
// Notes: no clocking block; testbench samples directly
`timescale 1ns/1ps
interface mhh_link_if;
   logic measure_trigger_in_n;
   logic contact_check_req_n;
   logic capacitance_open_corr_req_n;
   logic resistance_open_corr_req_n;
   logic conv_done_n;
   logic end_of_meas_n;
   logic alarm_n;
   logic [7:0] below_limit_out_n;
   logic [7:0] within_limit_out_n;
   logic [7:0] above_limit_out_n;
   logic [7:0] no_contact_out_n;
   modport dev (
      input measure_trigger_in_n, contact_check_req_n, capacitance_open_corr_req_n, resistance_open_corr_req_n,
      output conv_done_n, end_of_meas_n, alarm_n, below_limit_out_n, within_limit_out_n, above_limit_out_n,
      no_contact_out_n
   );
   modport host (
      output measure_trigger_in_n, contact_check_req_n, capacitance_open_corr_req_n, resistance_open_corr_req_n,
      input conv_done_n, end_of_meas_n, alarm_n, below_limit_out_n, within_limit_out_n, above_limit_out_n,
      no_contact_out_n
   );
endinterface

// file: mhh_map.svh
// Purpose: timing counts and widths for the measurement handler handshake
// Assumes: 250 MHz clock, 4 ns period
// Notes: times kept in their own unit; cycle counts derived from them
`ifndef MHH_MAP_SVH
`define MHH_MAP_SVH
`define MHH_CLK_MHZ 250
`define MHH_CHANNELS 8
`define MHH_MIN_PULSE_US 100
`define MHH_MIN_HIGH_US 100
`define MHH_ACK_NORM_US 200
`define MHH_ACK_CORR_US 400
`define MHH_EOM_AFTER_US 500
`define MHH_NOCONT_MS 3
`define MHH_SETUP_DISP_MS 30
`define MHH_SETUP_NODISP_MS 1
`define MHH_CX_INDEX_MS 8
`define MHH_CX_EOM_MS 10
`define MHH_IR_EACH_S 5
`define MHH_CC_PHASE_MS 4
`define MHH_JUDGE_SETUP_US 100
`define MHH_POST_SETUP_S 2
`define MHH_US_CYC(t) ((t) * `MHH_CLK_MHZ)
`define MHH_MS_CYC(t) ((t) * 1000 * `MHH_CLK_MHZ)
`define MHH_S_CYC(t) ((t) * 1000000 * `MHH_CLK_MHZ)
`endif

// file: mhh_pkg.sv
// Purpose: shared types for both ends of the handshake
// Assumes: nothing beyond the map header
// Notes: request kinds and state enums
package mhh_pkg;
   typedef enum logic [1:0] {MHH_REQ_MEAS, MHH_REQ_CHECK, MHH_REQ_CX, MHH_REQ_IR} mhh_req_t;
   typedef enum {MHH_D_IDLE, MHH_D_ACK, MHH_D_CONV, MHH_D_EOM, MHH_D_HOLD} mhh_dev_state_t;
   typedef enum {MHH_H_IDLE, MHH_H_PULSE, MHH_H_WAIT_EOM, MHH_H_SETUP} mhh_host_state_t;
endpackage
